// ===== design/sleep_ctl.v
// sleep mode control, peripheral clock gating and brown-out sleep-off sequencing
`timescale 1ns/1ns
`include "sleep_ctl_regs.vh"

// Summary of operation
// - mode 110 with crystal enters standby
// - mode 111 with crystal enters extended standby
// - wake from standby modes in six cycles unless the detector was off
// - mode field bits 3..1 decodes sleep modes
// - sleep only when arm bit is one
// - gate bit stops clock, blocks register access
// - clearing gate bit resumes frozen peripheral
// - gating acts in active and idle only
// - converter stays enabled; restart gives extended conversion
// - comparator auto-off in deep sleep modes unless on the reference
// - reference powered when detector, comparator, converter need
// - fused detector stays active sleeping unless sleep-off was taken; watchdog stays active
// - input buffers off when both clocks stopped, wake pins excepted
// - debug enabled keeps main clock running asleep
// - debug disable bit 7 turns debug off
// - sleep-off bit set by timed unlock sequence
// - sleep-off effective after three, cleared after three
// - interrupt wake halts core four extra cycles
// - wake after detector off takes about 60 us
// - clock gate register at 0x64, reset zero
module sleep_ctl #(
    parameter BOD_WAKE_CYCLES = `BOD_WAKE_CYC
) (
    // clock and reset
    input  wire       clk,
    input  wire       srst,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // core handshake
    input  wire       sleep_instr,
    input  wire       wake_irq,
    output reg        core_halted,
    output wire       sleep_entered,
    // straps and fuses
    input  wire       crystal_clock_sel,
    input  wire       debug_enable_fuse,
    input  wire       scan_port_fuse,
    input  wire       brownout_fuse_en,
    input  wire       watchdog_en,
    input  wire       converter_en,
    input  wire       comparator_en,
    input  wire       comparator_uses_ref,
    input  wire       wake_pin_needed,
    // peripheral side
    output wire [7:0] periph_clk_en,
    output wire [7:0] periph_reg_access_en,
    output wire       peripheral_clock_run,
    output wire       converter_clock_run,
    output wire       main_osc_run,
    output wire       converter_active,
    output reg        converter_extended_conv,
    output wire       comparator_active,
    output wire       reference_on,
    output wire       brownout_detector_on,
    output wire       watchdog_active,
    output wire       input_buffer_en,
    output wire       on_chip_debug_en
);

    // sleep state codes and wake counter width
    localparam ST_RUN    = 2'h0;
    localparam ST_SLEEP  = 2'h1;
    localparam ST_WAKE   = 2'h2;
    localparam ST_HALT   = 2'h3;
    localparam WAKE_W    = 16;

    // timing counts sized to the counters that load them
    localparam integer UNLOCK_WIN_I = `UNLOCK_WINDOW_CYC;
    localparam integer BOD_DELAY_I  = `BOD_OFF_DELAY_CYC;
    localparam integer BOD_HOLD_I   = `BOD_OFF_DELAY_CYC + `BOD_OFF_HOLD_CYC;
    localparam integer STANDBY_I    = `STANDBY_WAKE_CYC;
    localparam integer HALT_I       = `WAKE_HALT_CYC;
    localparam [2:0]   UNLOCK_WIN   = UNLOCK_WIN_I[2:0];
    localparam [2:0]   BOD_DELAY    = BOD_DELAY_I[2:0];
    localparam [2:0]   BOD_HOLD     = BOD_HOLD_I[2:0];
    localparam [15:0]  STANDBY_WAKE = STANDBY_I[15:0];
    localparam [15:0]  HALT_WAKE    = HALT_I[15:0];

    // software-visible registers
    reg  [7:0]        core_control_reg;
    reg  [7:0]        sleep_control_reg;
    reg  [7:0]        clock_gate_reg_a;

    // sleep state and wake counting
    reg  [1:0]        state_reg;
    reg  [2:0]        mode_reg;
    reg               bod_off_sleep_reg;
    reg  [WAKE_W-1:0] wake_cnt_reg;

    // sleep-off sequence counters
    reg  [2:0]        unlock_cnt_reg;
    reg  [2:0]        bod_delay_reg;
    reg  [2:0]        bod_hold_reg;
    reg               brownout_sleep_off;

    // converter restart tracking
    reg               converter_en_d_reg;
    reg               conv_restart_reg;

    // field views of the control registers
    wire [2:0] sleep_mode_select = sleep_control_reg[`BIT_MODE_HI:`BIT_MODE_LO];
    wire       sleep_arm         = sleep_control_reg[`BIT_SLEEP_ARM];
    wire       debug_port_disable = core_control_reg[`BIT_DEBUG_DISABLE];

    // write decode and sleep-off status
    wire       wr_core = reg_wr && (reg_addr == `OFF_CORE_CONTROL);
    wire       bod_active_now = brownout_sleep_off && (bod_delay_reg == 3'h0);

    // state decode
    wire       asleep = (state_reg == ST_SLEEP);

    // sleep mode decode: valid codes only, standby needs crystal clock
    // reserved codes leave the core running as if nothing was issued
    function mode_valid;
        input [2:0] m;
        input       xtal;
        begin
            case (m)
                `MODE_IDLE, `MODE_NOISE_RED, `MODE_POWER_DOWN, `MODE_POWER_SAVE: mode_valid = 1'b1;
                `MODE_STANDBY, `MODE_EXT_STANDBY: mode_valid = xtal;
                default: mode_valid = 1'b0;
            endcase
        end
    endfunction

    // true for modes that keep the peripheral clock running
    function io_clock_runs;
        input [2:0] m;
        begin
            io_clock_runs = (m == `MODE_IDLE);
        end
    endfunction

    // true for modes that keep the converter clock running
    function conv_clock_runs;
        input [2:0] m;
        begin
            conv_clock_runs = (m == `MODE_IDLE) || (m == `MODE_NOISE_RED);
        end
    endfunction

    // true for the two modes that keep the oscillator for a fast wake
    function is_standby;
        input [2:0] m;
        begin
            is_standby = (m == `MODE_STANDBY) || (m == `MODE_EXT_STANDBY);
        end
    endfunction

    // register writes and the timed sleep-off sequence
    // sleep-off only sets on the second write of the pair,
    // so one stray write can never switch the detector off
    always @(posedge clk) begin
        if (srst) begin
            core_control_reg  <= `RST_CORE_CONTROL;
            sleep_control_reg <= `RST_SLEEP_CONTROL;
            clock_gate_reg_a  <= `RST_CLOCK_GATE_A;
            unlock_cnt_reg    <= 3'h0;
            bod_delay_reg     <= 3'h0;
            bod_hold_reg      <= 3'h0;
            brownout_sleep_off <= 1'b0;
        end else begin
            // sleep control: mode field and arm bit, upper nibble zero
            if (reg_wr && reg_addr == `OFF_SLEEP_CONTROL)
                sleep_control_reg <= {4'h0, reg_wdata[3:0]};

            // clock gate register: one bit per peripheral
            if (reg_wr && reg_addr == `OFF_CLOCK_GATE_A)
                clock_gate_reg_a <= reg_wdata;

            // unlock window countdown
            if (unlock_cnt_reg != 3'h0)
                unlock_cnt_reg <= unlock_cnt_reg - 3'h1;

            // core control: plain bits stored, sleep-off pair decoded
            if (wr_core) begin
                // read-only bits and the two sequence bits never stored
                core_control_reg <= reg_wdata & ~`CORE_CTRL_RO_MASK & ~8'h60;
                if (reg_wdata[`BIT_BOD_OFF] && reg_wdata[`BIT_BOD_UNLOCK]) begin
                    // first write of the pair opens the window
                    unlock_cnt_reg <= UNLOCK_WIN;
                end else if (reg_wdata[`BIT_BOD_OFF] && !reg_wdata[`BIT_BOD_UNLOCK]
                             && unlock_cnt_reg != 3'h0) begin
                    // second write inside the window sets sleep-off
                    brownout_sleep_off <= 1'b1;
                    bod_delay_reg      <= BOD_DELAY;
                    bod_hold_reg       <= BOD_HOLD;
                    unlock_cnt_reg     <= 3'h0;
                end
            end

            // sleep-off becomes active after three, clears three later
            // a new set in the same cycle wins over the countdown
            if (brownout_sleep_off && !(wr_core && reg_wdata[`BIT_BOD_OFF])) begin
                if (bod_delay_reg != 3'h0)
                    bod_delay_reg <= bod_delay_reg - 3'h1;
                if (bod_hold_reg == 3'h1)
                    brownout_sleep_off <= 1'b0;
                if (bod_hold_reg != 3'h0)
                    bod_hold_reg <= bod_hold_reg - 3'h1;
            end
        end
    end

    // sleep state machine: entry, sleep, wake start-up, halt
    // the core stays halted through the whole wake path and the
    // extra halt cycles, so nothing it issues can race the wake
    always @(posedge clk) begin
        if (srst) begin
            state_reg         <= ST_RUN;
            mode_reg          <= `MODE_IDLE;
            bod_off_sleep_reg <= 1'b0;
            wake_cnt_reg      <= {WAKE_W{1'b0}};
            core_halted       <= 1'b0;
        end else begin
            case (state_reg)
                // running: take the sleep instruction when armed and valid
                ST_RUN: begin
                    if (sleep_instr && sleep_arm && mode_valid(sleep_mode_select, crystal_clock_sel)) begin
                        state_reg         <= ST_SLEEP;
                        mode_reg          <= sleep_mode_select;
                        // detector off only in the deeper modes
                        bod_off_sleep_reg <= bod_active_now && !conv_clock_runs(sleep_mode_select);
                        core_halted       <= 1'b1;
                    end
                end

                // asleep: an enabled interrupt starts the wake path
                ST_SLEEP: begin
                    if (wake_irq) begin
                        state_reg <= ST_WAKE;
                        // start-up length by mode and detector state
                        if (bod_off_sleep_reg)
                            wake_cnt_reg <= BOD_WAKE_CYCLES[WAKE_W-1:0];
                        else if (is_standby(mode_reg))
                            wake_cnt_reg <= STANDBY_WAKE;
                        else
                            wake_cnt_reg <= 16'h0001;
                    end
                end

                // start-up: detector back on, start-up time counted
                // the long count after a detector-off sleep lets it settle
                ST_WAKE: begin
                    bod_off_sleep_reg <= 1'b0;
                    if (wake_cnt_reg <= 16'h0001) begin
                        state_reg    <= ST_HALT;
                        wake_cnt_reg <= HALT_WAKE;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg - 16'h0001;
                    end
                end

                // halt: extra cycles before the core resumes
                ST_HALT: begin
                    if (wake_cnt_reg <= 16'h0001) begin
                        state_reg   <= ST_RUN;
                        core_halted <= 1'b0;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg - 16'h0001;
                    end
                end

                // unused code: back to running
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // converter restart tracking: next conversion after re-enable is long
    // the flag clears only after the converter has run with its clock,
    // so a switch-off inside a sleep still forces the long conversion
    always @(posedge clk) begin
        if (srst) begin
            converter_en_d_reg      <= 1'b0;
            conv_restart_reg        <= 1'b1;
            converter_extended_conv <= 1'b1;
        end else begin
            converter_en_d_reg <= converter_en;
            if (!converter_en)
                conv_restart_reg <= 1'b1;
            else if (converter_en_d_reg && converter_clock_run)
                conv_restart_reg <= 1'b0;
            converter_extended_conv <= conv_restart_reg;
        end
    end

    // register reads, one cycle later
    // data stands one cycle only; idle cycles read zero
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFF_CORE_CONTROL:  reg_rdata <= {core_control_reg[7],       // debug disable
                                                  brownout_sleep_off,        // sleep-off set
                                                  unlock_cnt_reg != 3'h0,    // unlock window open
                                                  core_control_reg[4],       // plain bit
                                                  2'b00,                     // read-only bits
                                                  core_control_reg[1:0]};
                `OFF_SLEEP_CONTROL: reg_rdata <= sleep_control_reg;
                `OFF_CLOCK_GATE_A:  reg_rdata <= clock_gate_reg_a;
                `OFF_SLEEP_STATUS:  reg_rdata <= {3'h0, bod_active_now, asleep, mode_reg};
                default:            reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // sleep state seen by the core
    assign sleep_entered = asleep;

    // peripheral clock: only idle keeps it in sleep
    assign peripheral_clock_run = !asleep || io_clock_runs(mode_reg);

    // converter clock: idle and noise reduction keep it
    assign converter_clock_run = !asleep || conv_clock_runs(mode_reg);

    // main oscillator: stopped only in power-down and power-save
    // debug keeps it running so the debugger never loses the core
    assign main_osc_run = !asleep
                          || conv_clock_runs(mode_reg)
                          || is_standby(mode_reg)
                          || on_chip_debug_en;

    // per-peripheral clock enables on top of the sleep clocks
    // gating only matters while the peripheral clock runs at all
    assign periph_clk_en = peripheral_clock_run ? ~clock_gate_reg_a : 8'h00;

    // register access blocked while a peripheral is gated
    assign periph_reg_access_en = ~clock_gate_reg_a;

    // converter keeps its enable through every sleep mode
    assign converter_active = converter_en;

    // comparator drops with the converter clock unless on the reference
    assign comparator_active = comparator_en && (converter_clock_run || comparator_uses_ref);

    // detector off only inside a sleep that took the sleep-off
    // leaving sleep turns it back on before the core resumes
    assign brownout_detector_on = brownout_fuse_en && !(asleep && bod_off_sleep_reg);

    // reference follows its three users
    assign reference_on = brownout_detector_on || comparator_active || converter_active;

    // watchdog is not touched by sleep
    assign watchdog_active = watchdog_en;

    // input buffers off when both clocks stop, wake pins excepted
    // floating pins then draw no current through the input stage
    assign input_buffer_en = peripheral_clock_run || converter_clock_run || wake_pin_needed;

    // debug off by the disable bit or either fuse
    assign on_chip_debug_en = debug_enable_fuse && scan_port_fuse && !debug_port_disable;

endmodule

// ===== design/sleep_ctl_regs.vh
// register offsets, fields, reset values and timing counts of the sleep and clock gating control
`ifndef SLEEP_CTL_REGS_VH
`define SLEEP_CTL_REGS_VH

`define OFF_CORE_CONTROL    8'h35
`define OFF_SLEEP_CONTROL   8'h33
`define OFF_CLOCK_GATE_A    8'h64
`define OFF_SLEEP_STATUS    8'h70

`define RST_CORE_CONTROL    8'h00
`define RST_SLEEP_CONTROL   8'h00
`define RST_CLOCK_GATE_A    8'h00

`define BIT_SLEEP_ARM       0
`define BIT_MODE_LO         1
`define BIT_MODE_HI         3
`define BIT_DEBUG_DISABLE   7
`define BIT_BOD_OFF         6
`define BIT_BOD_UNLOCK      5
`define CORE_CTRL_RO_MASK   8'h0c

`define MODE_IDLE           3'h0
`define MODE_NOISE_RED      3'h1
`define MODE_POWER_DOWN     3'h2
`define MODE_POWER_SAVE     3'h3
`define MODE_STANDBY        3'h6
`define MODE_EXT_STANDBY    3'h7

`define UNLOCK_WINDOW_CYC   4
`define BOD_OFF_DELAY_CYC   3
`define BOD_OFF_HOLD_CYC    3
`define STANDBY_WAKE_CYC    6
`define WAKE_HALT_CYC       4
`define BOD_WAKE_TIME_NS    60000
`define CLK_PERIOD_NS       4
`define BOD_WAKE_CYC        ((`BOD_WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== test/sleep_ctl_chk.sv
// port assertions for the sleep and clock gating control
`timescale 1ns/1ns
`include "sleep_ctl_regs.vh"
module sleep_ctl_chk (
    // clock, reset and register port
    input wire logic       clk, srst, reg_wr, reg_rd,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    // core and straps
    input wire logic       sleep_instr, core_halted, sleep_entered, converter_en, comparator_uses_ref,
    input wire logic       wake_pin_needed,
    // peripheral side
    input wire logic [7:0] periph_clk_en, periph_reg_access_en,
    input wire logic       peripheral_clock_run, converter_clock_run, main_osc_run, converter_extended_conv,
    input wire logic       comparator_active, reference_on, brownout_detector_on, converter_active,
    input wire logic       input_buffer_en, on_chip_debug_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // entry and wake steps
    sequence s_entry; $rose(sleep_entered); endsequence
    sequence s_halt4; core_halted [*4]; endsequence
    property p_entry; s_entry |-> $past(sleep_instr); endproperty
    a_entry: assert property (p_entry) else $error("sleep without instruction");
    property p_halt; $fell(sleep_entered) |-> s_halt4; endproperty
    a_halt: assert property (p_halt) else $error("core released early");
    // active mode clocks and gating
    property p_run; !core_halted |-> peripheral_clock_run && converter_clock_run && main_osc_run; endproperty
    a_run: assert property (p_run) else $error("clock stopped while running");
    property p_gate; !core_halted |-> periph_clk_en == periph_reg_access_en; endproperty
    a_gate: assert property (p_gate) else $error("gating and access differ");
    // buffers and analog side
    property p_ibuf; sleep_entered && !converter_clock_run && !wake_pin_needed |-> !input_buffer_en; endproperty
    a_ibuf: assert property (p_ibuf) else $error("input buffer on in deep sleep");
    property p_ibuf_run; !sleep_entered |-> input_buffer_en; endproperty
    a_ibuf_run: assert property (p_ibuf_run) else $error("input buffer off while awake");
    property p_ref; brownout_detector_on || converter_active |-> reference_on; endproperty
    a_ref: assert property (p_ref) else $error("reference off while needed");
    property p_cmp; !peripheral_clock_run && !converter_clock_run && !comparator_uses_ref |-> !comparator_active; endproperty
    a_cmp: assert property (p_cmp) else $error("comparator on in deep sleep");
    property p_ext; $fell(converter_en) |-> ##[1:2] converter_extended_conv; endproperty
    a_ext: assert property (p_ext) else $error("no extended conversion");
    // core control register
    property p_dbg; reg_wr && reg_addr == `OFF_CORE_CONTROL && reg_wdata[7] |=> !on_chip_debug_en; endproperty
    a_dbg: assert property (p_dbg) else $error("debug still enabled");
    property p_ro; reg_rd && reg_addr == `OFF_CORE_CONTROL |=> reg_rdata[3:2] == 2'b00; endproperty
    a_ro: assert property (p_ro) else $error("read-only bits nonzero");
endmodule
bind sleep_ctl sleep_ctl_chk u_chk (.*);

// ===== test/core_model.sv
// core and gated timer stand-in on the far side of the sleep control
`timescale 1ns/1ns
module core_model (
    // clock and reset
    input  wire logic       clk, srst,
    // bench requests and controller side
    input  wire logic       do_sleep, do_wake, core_halted, timer_clk_en,
    output logic            sleep_instr, wake_irq,
    output logic [7:0]      timer_count
);
    // halted core issues nothing; interrupt pending until core runs
    always @(posedge clk) begin
        if (srst) begin
            sleep_instr <= 1'b0;
            wake_irq    <= 1'b0;
            timer_count <= 8'h00;
        end else begin
            sleep_instr <= do_sleep && !core_halted;
            wake_irq    <= do_wake || (wake_irq && core_halted);
            if (timer_clk_en)
                timer_count <= timer_count + 8'h01;
        end
    end
endmodule

// ===== test/test_sleep_ctl.sv
// self-checking bench for the sleep and clock gating control
`timescale 1ns/1ns
`include "sleep_ctl_regs.vh"
module test_sleep_ctl;
    // stimulus and observed signals
    logic       clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, do_sleep = 1'b0, do_wake = 1'b0;
    logic       xtal = 1'b1, fuse = 1'b1, conv_en = 1'b1, wpin = 1'b0, cref = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, clk_en, acc_en, tcount, v;
    logic       sleep_instr, wake_irq, halted, asleep, osc, pclk, cclk, bod_on, dbg_en, ibuf, wdog, cmpa, refon, ext;
    logic [2:0] m;
    int         miscompares = 0, checks = 0, base = 0, n;
    always #2 clk = ~clk;
    sleep_ctl #(.BOD_WAKE_CYCLES(20)) u_dut (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_instr(sleep_instr), .wake_irq(wake_irq), .core_halted(halted),
        .sleep_entered(asleep), .crystal_clock_sel(xtal), .debug_enable_fuse(fuse), .scan_port_fuse(fuse),
        .brownout_fuse_en(1'b1), .watchdog_en(1'b1), .converter_en(conv_en), .comparator_en(1'b1),
        .comparator_uses_ref(cref), .wake_pin_needed(wpin), .periph_clk_en(clk_en), .periph_reg_access_en(acc_en),
        .peripheral_clock_run(pclk), .converter_clock_run(cclk), .main_osc_run(osc), .converter_active(),
        .converter_extended_conv(ext), .comparator_active(cmpa), .reference_on(refon), .brownout_detector_on(bod_on),
        .watchdog_active(wdog), .input_buffer_en(ibuf), .on_chip_debug_en(dbg_en));
    core_model u_core (.clk(clk), .srst(srst), .do_sleep(do_sleep), .do_wake(do_wake), .core_halted(halted),
        .timer_clk_en(clk_en[5]), .sleep_instr(sleep_instr), .wake_irq(wake_irq), .timer_count(tcount));
    task automatic cmp(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read, data taken in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, want);
    endtask
    // sleep instruction from the core, entry settles
    task automatic fire;
        @(posedge clk);
        do_sleep <= 1'b1;
        @(posedge clk);
        do_sleep <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // interrupt wake, cycles counted until the core runs
    task automatic wake;
        @(posedge clk);
        do_wake <= 1'b1;
        @(posedge clk);
        do_wake <= 1'b0;
        #1;
        for (n = 0; n < 200 && halted !== 1'b0; n++)
            @(posedge clk) #1;
        if (n == 200) begin
            miscompares++;
            finish_test();
        end
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd_chk(`OFF_CORE_CONTROL, `RST_CORE_CONTROL);
        rd_chk(`OFF_CLOCK_GATE_A, `RST_CLOCK_GATE_A);
        rd_chk(8'h10, 8'h00);
        wr(`OFF_CORE_CONTROL, 8'h9f);
        rd_chk(`OFF_CORE_CONTROL, 8'h93);
        cmp(dbg_en, 8'h00);
        wr(`OFF_CORE_CONTROL, 8'h00);
        cmp(dbg_en, 8'h01);
        // gated timer freezes and resumes where it stopped
        wr(`OFF_CLOCK_GATE_A, 8'h20);
        cmp(clk_en, 8'hdf);
        cmp(acc_en, 8'hdf);
        v = tcount;
        repeat (4) @(posedge clk);
        #1;
        cmp(tcount, v);
        wr(`OFF_CLOCK_GATE_A, 8'h00);
        @(posedge clk) #1;
        cmp(tcount, v + 8'h01);
        // unarmed sleep does nothing
        wr(`OFF_SLEEP_CONTROL, 8'h04);
        fire();
        cmp(asleep, 8'h00);
        // every mode code, last pass standby with no crystal
        for (int i = 0; i < 9; i++) begin
            m = (i == 8) ? 3'h6 : i[2:0];
            @(posedge clk);
            xtal <= (i != 8);
            wpin <= i[0];
            fuse <= 1'b0;
            cref <= (i == 7);
            wr(`OFF_SLEEP_CONTROL, {4'h0, m, 1'b1});
            fire();
            cmp(asleep, (m[2:1] != 2'b10 && i != 8));
            if (asleep === 1'b1) begin
                cmp({osc, pclk, cclk, ibuf}, {m != 3'h2 && m != 3'h3, m == 3'h0, m < 3'h2, m < 3'h2 || wpin});
                cmp({wdog, cmpa, refon}, {1'b1, m < 3'h2 || cref, 1'b1});
                rd_chk(`OFF_SLEEP_STATUS, {5'h01, m});
                wake();
                base = (i == 0) ? n : base;
                cmp(8'(n), 8'(base + (m[2] ? 5 : 0)));
            end
            wr(`OFF_SLEEP_CONTROL, 8'h00);
        end
        // late second write of the unlock is refused
        @(posedge clk);
        xtal <= 1'b1;
        wr(`OFF_CORE_CONTROL, 8'h60);
        repeat (6) @(posedge clk);
        wr(`OFF_CORE_CONTROL, 8'h40);
        rd_chk(`OFF_CORE_CONTROL, 8'h00);
        // timed unlock, sleep while sleep-off is active
        wr(`OFF_SLEEP_CONTROL, 8'h05);
        wr(`OFF_CORE_CONTROL, 8'h60);
        wr(`OFF_CORE_CONTROL, 8'h40);
        @(posedge clk);
        fire();
        cmp(bod_on, 8'h00);
        wake();
        cmp(8'(n), 8'(base + 19));
        cmp(bod_on, 8'h01);
        wr(`OFF_SLEEP_CONTROL, 8'h00);
        // converter disabled while gate bit 0 is set and cleared, then back on
        @(posedge clk);
        conv_en <= 1'b0;
        wr(`OFF_CLOCK_GATE_A, 8'h01);
        cmp(clk_en, 8'hfe);
        wr(`OFF_CLOCK_GATE_A, 8'h00);
        @(posedge clk);
        conv_en <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        cmp(ext, 8'h01);
        finish_test();
    end
endmodule
